// *** design/ubc_pkg.sv ***
// Constants for the serial port control and pin block: register offsets,
// field positions, reset values and baud divider figures.
// Assumes an 8-bit special function register port and a 250 MHz core clock.
//
// Contract
// - In modes 1 and 3 the baud source is the timer 1 overflow when bit 7 of the source register is 0, else the reload registers.
// - Writing the serial data buffer starts sending that byte, least significant bit first.
// - A received byte becomes readable at the serial data buffer address once its whole frame is in.
// - In mode 2 the core clock is divided by 64 with the doubling bit at 0 and by 32 with it at 1.
// - The doubling bit has no effect in mode 0.
// - The serial interrupt reaches the CPU only when global enable bit 7 and serial enable bit 4 are both set.
// - The transmit pin is push-pull with its open-drain bit 3 at 0 and open-drain with it at 1.
// - With the receive pin open-drain bit 2 at 1 the receiver takes in nothing.
// - The transmit pin carries serial data only while its direction bit 3 selects output.
// - The receive pin feeds the receiver only while its direction bit 2 selects input.
// - The transmitter only pulls the pin low, so latch bit 3 must be 1 for data and 0 holds the pin low.
// - Reading port bit 2 returns the present level of the receive line at any time.
// - With the reload source the rate is 2^double times fcpu over 64 times (1024 minus the reload).
// - With the timer 1 source the rate is 2^double over 32 timer 1 overflow periods.
// - The doubling bit doubles the rate of the chosen generator in modes 1 and 3.
// - The transmit-done flag sets at the start of the stop bit of each sent frame.

package ubc_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_PORT0_LATCH   = 8'h80;
  localparam logic [7:0] ADDR_POWER_DOUBLE  = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CTRL   = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_DATA   = 8'h99;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h9a;
  localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h9c;
  localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h9d;
  localparam logic [7:0] ADDR_IRQ_ENABLE0   = 8'ha8;
  localparam logic [7:0] ADDR_BAUD_SOURCE   = 8'hd8;
  localparam logic [7:0] ADDR_PORT0_OD      = 8'he4;
  localparam logic [7:0] ADDR_PORT0_DIR     = 8'hf9;

  // Field positions
  localparam int BIT_BAUD_SOURCE   = 7;
  localparam int BIT_BAUD_DOUBLE   = 7;
  localparam int BIT_GLOBAL_IRQ    = 7;
  localparam int BIT_SERIAL_IRQ    = 4;
  localparam int BIT_TX_PIN        = 3;
  localparam int BIT_RX_PIN        = 2;
  localparam int BIT_MODE_HI       = 7;
  localparam int BIT_MODE_LO       = 6;
  localparam int BIT_MULTIPROC     = 5;
  localparam int BIT_RX_ENABLE     = 4;
  localparam int BIT_TX_NINTH      = 3;
  localparam int BIT_RX_NINTH      = 2;
  localparam int BIT_TX_DONE       = 1;
  localparam int BIT_RX_DONE       = 0;

  // Reset values
  localparam logic [7:0] RST_REG8      = 8'h00;
  localparam logic [7:0] RST_LATCH     = 8'hff;
  localparam logic [7:0] RST_IRQ_MASK  = 8'h03;

  // Baud figures
  localparam int        OS_RATE      = 16;
  localparam int        OS_RATE_M0   = 4;
  localparam logic [12:0] DIV_M0     = 13'h0003;
  localparam logic [12:0] DIV_M2_X1  = 13'h0004;
  localparam logic [12:0] DIV_M2_X2  = 13'h0002;
  localparam logic [12:0] DIV_T1_X1  = 13'h0002;
  localparam logic [12:0] DIV_T1_X2  = 13'h0001;
  localparam logic [10:0] RELOAD_TOP = 11'h400;
  localparam real         CLK_MHZ    = 250.0;

endpackage

// *** design/ubc_baud_gen.sv ***
// Oversampling tick generator for the serial port.
// Assumes the timer 1 overflow strobe comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module ubc_baud_gen (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // Configuration
  input  wire logic [1:0] mode_i,
  input  wire logic       src_reload_i,
  input  wire logic       dbl_i,
  input  wire logic [9:0] reload_i,
  input  wire logic       t1_ovf_i,
  // Tick out
  output logic            tick_o
);

  logic [12:0] cnt_ff;
  logic [12:0] nxt_cnt;
  logic [12:0] div;
  logic [12:0] rel_div;
  logic        use_t1;
  logic        step;
  logic        hit;

  localparam logic [10:0] RELOAD_TOP_W = ubc_pkg::RELOAD_TOP;

  // Ticks: 16 per bit in modes 1 to 3, 4 per bit in mode 0
  assign rel_div = {RELOAD_TOP_W - {1'b0, reload_i}, 2'b00} >> dbl_i;
  assign use_t1  = mode_i[0] && !src_reload_i;
  assign div     = (mode_i == 2'd0) ? ubc_pkg::DIV_M0 :
                   (mode_i == 2'd2) ? (dbl_i ? ubc_pkg::DIV_M2_X2 : ubc_pkg::DIV_M2_X1) :
                   use_t1 ? (dbl_i ? ubc_pkg::DIV_T1_X2 : ubc_pkg::DIV_T1_X1) :
                   rel_div;
  assign step    = use_t1 ? t1_ovf_i : 1'b1;
  assign hit     = step && (cnt_ff >= div - 13'h0001);
  assign nxt_cnt = hit ? 13'h0000 : (step ? cnt_ff + 13'h0001 : cnt_ff);

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      cnt_ff <= 13'h0000;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick_o <= hit;
    end
  end

  // Configuration change cancels spacing checks in flight
  logic [13:0] cfg_ff;
  logic        cfg_chg;
  assign cfg_chg = ({mode_i, src_reload_i, dbl_i, reload_i} != cfg_ff);
  always_ff @(posedge core_clk_i) begin
    cfg_ff <= {mode_i, src_reload_i, dbl_i, reload_i};
  end

  property p_t1_source;
    @(posedge core_clk_i) disable iff (!nrst_i || cfg_chg)
    (mode_i[0] && !src_reload_i && !t1_ovf_i) |=> !tick_o;
  endproperty
  a_t1_source: assert property (p_t1_source) else $error("tick without timer 1 overflow");

  property p_mode2_x1;
    @(posedge core_clk_i) disable iff (!nrst_i || cfg_chg)
    (tick_o && mode_i == 2'd2 && !dbl_i) |=> !tick_o [*3] ##1 tick_o;
  endproperty
  a_mode2_x1: assert property (p_mode2_x1) else $error("mode 2 spacing not 4");

  property p_mode0_fixed;
    @(posedge core_clk_i) disable iff (!nrst_i || cfg_chg)
    (tick_o && mode_i == 2'd0) |=> !tick_o [*2] ##1 tick_o;
  endproperty
  a_mode0_fixed: assert property (p_mode0_fixed) else $error("mode 0 spacing not 3");

  property p_reload_top;
    @(posedge core_clk_i) disable iff (!nrst_i || cfg_chg)
    (tick_o && mode_i == 2'd1 && src_reload_i && dbl_i && reload_i == 10'h3ff)
      |=> !tick_o ##1 tick_o;
  endproperty
  a_reload_top: assert property (p_reload_top) else $error("reload spacing wrong");

endmodule // ubc_baud_gen

`default_nettype wire

// *** design/ubc_top.sv ***
// Serial port control, data buffer, interrupt gate and pin drivers.
// Assumes a one-cycle register port with read data the cycle after a read,
// and a pad that resolves the transmit pin from level and enable.
`timescale 1ns/100ps
`default_nettype none

module ubc_top (
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Timer 1 overflow strobe
  input  wire logic       t1_ovf_i,
  // Pins
  input  wire logic       serial_rx_pin_i,
  output logic            serial_tx_pin_o,
  output logic            serial_tx_pin_oe_o,
  // Interrupt
  output logic            serial_irq_o
);

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} ubc_state_type;

  // Registers
  logic [7:0] port0_data_latch_ff;
  logic [7:0] power_and_baud_double_control_ff;
  logic [7:0] serial_ctrl_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] baud_reload_low_ff;
  logic [1:0] baud_reload_high_ff;
  logic [7:0] interrupt_enable_zero_ff;
  logic       baud_source_select_ff;
  logic [7:0] port0_open_drain_control_ff;
  logic [7:0] port0_direction_control_ff;
  logic [7:0] rx_buf_ff;
  logic       tx_done_flag_ff;
  logic       rx_done_flag_ff;
  logic       rx_ninth_ff;

  // Decode
  wire wr_latch = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_PORT0_LATCH);
  wire wr_power = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_POWER_DOUBLE);
  wire wr_ctrl  = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_SERIAL_CTRL);
  wire wr_data  = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_SERIAL_DATA);
  wire wr_mask  = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_IRQ_MASK);
  wire wr_rel_l = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_RELOAD_LOW);
  wire wr_rel_h = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_RELOAD_HIGH);
  wire wr_ien   = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_IRQ_ENABLE0);
  wire wr_src   = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_BAUD_SOURCE);
  wire wr_od    = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_PORT0_OD);
  wire wr_dir   = reg_wr_i && (reg_addr_i == ubc_pkg::ADDR_PORT0_DIR);

  // Named control fields
  wire [1:0] mode         = serial_ctrl_ff[ubc_pkg::BIT_MODE_HI:ubc_pkg::BIT_MODE_LO];
  wire       nine_bit     = mode[1];
  wire       multiproc    = serial_ctrl_ff[ubc_pkg::BIT_MULTIPROC];
  wire       rx_enable    = serial_ctrl_ff[ubc_pkg::BIT_RX_ENABLE];
  wire       tx_ninth     = serial_ctrl_ff[ubc_pkg::BIT_TX_NINTH];
  wire       baud_double  = power_and_baud_double_control_ff[ubc_pkg::BIT_BAUD_DOUBLE];
  wire       global_irq_enable = interrupt_enable_zero_ff[ubc_pkg::BIT_GLOBAL_IRQ];
  wire       serial_irq_enable = interrupt_enable_zero_ff[ubc_pkg::BIT_SERIAL_IRQ];
  wire       tx_pin_open_drain = port0_open_drain_control_ff[ubc_pkg::BIT_TX_PIN];
  wire       rx_pin_open_drain = port0_open_drain_control_ff[ubc_pkg::BIT_RX_PIN];
  wire       tx_pin_direction  = port0_direction_control_ff[ubc_pkg::BIT_TX_PIN];
  wire       rx_pin_direction  = port0_direction_control_ff[ubc_pkg::BIT_RX_PIN];
  wire       tx_pin_latch      = port0_data_latch_ff[ubc_pkg::BIT_TX_PIN];

  // Baud ticks
  logic tick;
  ubc_baud_gen u_baud (
    .core_clk_i   (core_clk_i),
    .nrst_i       (nrst_i),
    .mode_i       (mode),
    .src_reload_i (baud_source_select_ff),
    .dbl_i        (baud_double),
    .reload_i     ({baud_reload_high_ff, baud_reload_low_ff}),
    .t1_ovf_i     (t1_ovf_i),
    .tick_o       (tick)
  );

  localparam logic [3:0] SUB_LAST    = 4'(ubc_pkg::OS_RATE - 1);
  localparam logic [3:0] SUB_LAST_M0 = 4'(ubc_pkg::OS_RATE_M0 - 1);
  localparam logic [3:0] SUB_MID     = 4'(ubc_pkg::OS_RATE / 2);
  localparam logic [3:0] SUB_MID_M0  = 4'(ubc_pkg::OS_RATE_M0 / 2);
  wire [3:0] sub_last = (mode == 2'd0) ? SUB_LAST_M0 : SUB_LAST;
  wire [3:0] sub_mid  = (mode == 2'd0) ? SUB_MID_M0 : SUB_MID;

  // Transmitter
  ubc_state_type tx_st_ff;
  ubc_state_type nxt_tx_st;
  logic [7:0]    tx_shift_ff;
  logic [3:0]    tx_sub_ff;
  logic [2:0]    tx_idx_ff;
  logic          tx_line_ff;

  wire tx_bit_end = tick && (tx_sub_ff == sub_last);
  wire tx_go      = wr_data && (tx_st_ff == ST_IDLE);
  wire tx_set     = tx_bit_end && (nxt_tx_st == ST_STOP) && (tx_st_ff != ST_STOP);

  always_comb begin
    nxt_tx_st = tx_st_ff;
    if (tx_go) begin
      nxt_tx_st = ST_START;
    end else if (tx_bit_end) begin
      case (tx_st_ff)
        ST_START: nxt_tx_st = ST_DATA;
        ST_DATA:  nxt_tx_st = (tx_idx_ff != 3'h7) ? ST_DATA : (nine_bit ? ST_NINTH : ST_STOP);
        ST_NINTH: nxt_tx_st = ST_STOP;
        ST_STOP:  nxt_tx_st = ST_IDLE;
        default:  nxt_tx_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tx_st_ff    <= ST_IDLE;
      tx_shift_ff <= ubc_pkg::RST_REG8;
      tx_sub_ff   <= 4'h0;
      tx_idx_ff   <= 3'h0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      if (tx_go) begin
        tx_shift_ff <= reg_wdata_i;
        tx_sub_ff   <= 4'h0;
        tx_idx_ff   <= 3'h0;
      end else if (tick && tx_st_ff != ST_IDLE) begin
        tx_sub_ff <= tx_bit_end ? 4'h0 : tx_sub_ff + 4'h1;
        if (tx_bit_end && tx_st_ff == ST_DATA) begin
          tx_shift_ff <= {1'b0, tx_shift_ff[7:1]};
          tx_idx_ff   <= tx_idx_ff + 3'h1;
        end
      end
    end
  end

  // Serial level before the pin gate
  always_comb begin
    case (tx_st_ff)
      ST_START: tx_line_ff = 1'b0;
      ST_DATA:  tx_line_ff = tx_shift_ff[0];
      ST_NINTH: tx_line_ff = tx_ninth;
      default:  tx_line_ff = 1'b1;
    endcase
  end

  // Pin level: the serial path can only pull low, the latch holds low too
  wire pin_level  = tx_pin_latch & tx_line_ff;
  wire nxt_tx_oe  = tx_pin_direction && (!tx_pin_open_drain || !pin_level);
  wire nxt_tx_pin = tx_pin_open_drain ? 1'b0 : pin_level;

  // Receive line synchroniser
  logic rx_meta_ff;
  logic rx_sync_ff;
  logic rx_prev_ff;
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_prev_ff <= 1'b1;
    end else begin
      rx_meta_ff <= serial_rx_pin_i;
      rx_sync_ff <= rx_meta_ff;
      rx_prev_ff <= rx_sync_ff;
    end
  end

  // Receiver
  ubc_state_type rx_st_ff;
  ubc_state_type nxt_rx_st;
  logic [7:0]    rx_shift_ff;
  logic [3:0]    rx_sub_ff;
  logic [2:0]    rx_idx_ff;
  logic          rx_bit9_ff;

  // Open-drain or output mode on the receive pin blocks reception
  wire rx_ok      = rx_enable && !rx_pin_open_drain && !rx_pin_direction;
  wire rx_fall    = rx_prev_ff && !rx_sync_ff;
  wire rx_mid     = tick && (rx_sub_ff == sub_mid);
  wire rx_bit_end = tick && (rx_sub_ff == sub_last);
  wire rx_stop_ok = rx_ok && rx_mid && (rx_st_ff == ST_STOP);
  wire rx_accept  = rx_stop_ok && !(multiproc && nine_bit && !rx_bit9_ff);
  wire rx_set     = rx_accept;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    if (!rx_ok) begin
      nxt_rx_st = ST_IDLE;
    end else begin
      case (rx_st_ff)
        ST_IDLE:  nxt_rx_st = rx_fall ? ST_START : ST_IDLE;
        ST_START: nxt_rx_st = (rx_mid && rx_sync_ff) ? ST_IDLE :
                              (rx_bit_end ? ST_DATA : ST_START);
        ST_DATA:  nxt_rx_st = (!rx_bit_end || rx_idx_ff != 3'h7) ? ST_DATA :
                              (nine_bit ? ST_NINTH : ST_STOP);
        ST_NINTH: nxt_rx_st = rx_bit_end ? ST_STOP : ST_NINTH;
        ST_STOP:  nxt_rx_st = rx_mid ? ST_IDLE : ST_STOP;
        default:  nxt_rx_st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      rx_st_ff    <= ST_IDLE;
      rx_shift_ff <= ubc_pkg::RST_REG8;
      rx_sub_ff   <= 4'h0;
      rx_idx_ff   <= 3'h0;
      rx_bit9_ff  <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      if (rx_st_ff == ST_IDLE) begin
        rx_sub_ff <= 4'h0;
        rx_idx_ff <= 3'h0;
        rx_bit9_ff <= 1'b1;
      end else if (tick) begin
        rx_sub_ff <= rx_bit_end ? 4'h0 : rx_sub_ff + 4'h1;
        if (rx_bit_end && rx_st_ff == ST_DATA) begin
          rx_idx_ff <= rx_idx_ff + 3'h1;
        end
        if (rx_mid && rx_st_ff == ST_DATA) begin
          rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
        end
        if (rx_mid && rx_st_ff == ST_NINTH) begin
          rx_bit9_ff <= rx_sync_ff;
        end
      end
    end
  end

  // Register writes
  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      port0_data_latch_ff              <= ubc_pkg::RST_LATCH;
      power_and_baud_double_control_ff <= ubc_pkg::RST_REG8;
      serial_ctrl_ff                   <= ubc_pkg::RST_REG8;
      irq_mask_ff                      <= ubc_pkg::RST_IRQ_MASK;
      baud_reload_low_ff               <= ubc_pkg::RST_REG8;
      baud_reload_high_ff              <= 2'h0;
      interrupt_enable_zero_ff         <= ubc_pkg::RST_REG8;
      baud_source_select_ff            <= 1'b0;
      port0_open_drain_control_ff      <= ubc_pkg::RST_REG8;
      port0_direction_control_ff       <= ubc_pkg::RST_REG8;
    end else begin
      if (wr_latch) port0_data_latch_ff <= reg_wdata_i;
      if (wr_power) power_and_baud_double_control_ff <= reg_wdata_i;
      if (wr_ctrl)  serial_ctrl_ff <= {reg_wdata_i[7:3], 3'h0};
      if (wr_mask)  irq_mask_ff <= {6'h00, reg_wdata_i[1:0]};
      if (wr_rel_l) baud_reload_low_ff <= reg_wdata_i;
      if (wr_rel_h) baud_reload_high_ff <= reg_wdata_i[1:0];
      if (wr_ien)   interrupt_enable_zero_ff <= reg_wdata_i;
      if (wr_src)   baud_source_select_ff <= reg_wdata_i[ubc_pkg::BIT_BAUD_SOURCE];
      if (wr_od)    port0_open_drain_control_ff <= reg_wdata_i;
      if (wr_dir)   port0_direction_control_ff <= reg_wdata_i;
    end
  end

  // Flags: write one to clear, a same-cycle event wins
  wire clr_tx = wr_ctrl && reg_wdata_i[ubc_pkg::BIT_TX_DONE];
  wire clr_rx = wr_ctrl && reg_wdata_i[ubc_pkg::BIT_RX_DONE];

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      tx_done_flag_ff <= 1'b0;
      rx_done_flag_ff <= 1'b0;
      rx_buf_ff       <= ubc_pkg::RST_REG8;
      rx_ninth_ff     <= 1'b0;
    end else begin
      tx_done_flag_ff <= (tx_done_flag_ff && !clr_tx) || tx_set;
      rx_done_flag_ff <= (rx_done_flag_ff && !clr_rx) || rx_set;
      if (rx_accept) begin
        rx_buf_ff   <= rx_shift_ff;
        rx_ninth_ff <= nine_bit ? rx_bit9_ff : rx_sync_ff;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  wire [7:0] ctrl_view = {serial_ctrl_ff[7:3], rx_ninth_ff, tx_done_flag_ff, rx_done_flag_ff};
  wire [7:0] latch_view = {port0_data_latch_ff[7:3], rx_sync_ff, port0_data_latch_ff[1:0]};
  wire [7:0] rd_mux =
    (reg_addr_i == ubc_pkg::ADDR_PORT0_LATCH)  ? latch_view :
    (reg_addr_i == ubc_pkg::ADDR_POWER_DOUBLE) ? power_and_baud_double_control_ff :
    (reg_addr_i == ubc_pkg::ADDR_SERIAL_CTRL)  ? ctrl_view :
    (reg_addr_i == ubc_pkg::ADDR_SERIAL_DATA)  ? rx_buf_ff :
    (reg_addr_i == ubc_pkg::ADDR_IRQ_MASK)     ? irq_mask_ff :
    (reg_addr_i == ubc_pkg::ADDR_RELOAD_LOW)   ? baud_reload_low_ff :
    (reg_addr_i == ubc_pkg::ADDR_RELOAD_HIGH)  ? {6'h00, baud_reload_high_ff} :
    (reg_addr_i == ubc_pkg::ADDR_IRQ_ENABLE0)  ? interrupt_enable_zero_ff :
    (reg_addr_i == ubc_pkg::ADDR_BAUD_SOURCE)  ? {baud_source_select_ff, 7'h00} :
    (reg_addr_i == ubc_pkg::ADDR_PORT0_OD)     ? port0_open_drain_control_ff :
    (reg_addr_i == ubc_pkg::ADDR_PORT0_DIR)    ? port0_direction_control_ff : 8'h00;

  // Both flags share one request behind the two enables
  wire irq_pend = (tx_done_flag_ff && irq_mask_ff[ubc_pkg::BIT_TX_DONE]) ||
                  (rx_done_flag_ff && irq_mask_ff[ubc_pkg::BIT_RX_DONE]);
  wire nxt_irq  = global_irq_enable && serial_irq_enable && irq_pend;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      reg_rdata_o        <= 8'h00;
      serial_tx_pin_o    <= 1'b0;
      serial_tx_pin_oe_o <= 1'b0;
      serial_irq_o       <= 1'b0;
    end else begin
      reg_rdata_o        <= reg_rd_i ? rd_mux : 8'h00;
      serial_tx_pin_o    <= nxt_tx_pin;
      serial_tx_pin_oe_o <= nxt_tx_oe;
      serial_irq_o       <= nxt_irq;
    end
  end

  // Checks
  sequence s_tx_kick;
    wr_data && (tx_st_ff == ST_IDLE);
  endsequence
  sequence s_tx_leaves_idle;
    (tx_st_ff == ST_START) ##1 (tx_st_ff == ST_START);
  endsequence

  property p_tx_start;
    @(posedge core_clk_i) disable iff (!nrst_i)
    s_tx_kick |=> s_tx_leaves_idle;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start frame");

  property p_tx_done_at_stop;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $rose(tx_done_flag_ff) |-> (tx_st_ff == ST_STOP) && ($past(tx_st_ff) != ST_STOP);
  endproperty
  a_tx_done_at_stop: assert property (p_tx_done_at_stop) else $error("done not at stop");

  property p_irq_gate;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (!global_irq_enable || !serial_irq_enable) |=> !serial_irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt passed closed gate");

  property p_flag_sticky;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (rx_done_flag_ff && !clr_rx) |=> rx_done_flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped uncleared");

  property p_open_drain;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $past(tx_pin_open_drain) |-> !(serial_tx_pin_oe_o && serial_tx_pin_o);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

  property p_rx_blocked;
    @(posedge core_clk_i) disable iff (!nrst_i)
    (rx_pin_open_drain || rx_pin_direction)
      |=> (rx_st_ff == ST_IDLE) && !$rose(rx_done_flag_ff);
  endproperty
  a_rx_blocked: assert property (p_rx_blocked) else $error("receiver ran while blocked");

  property p_latch_low;
    @(posedge core_clk_i) disable iff (!nrst_i)
    $past(tx_pin_direction && !tx_pin_latch) |-> serial_tx_pin_oe_o && !serial_tx_pin_o;
  endproperty
  a_latch_low: assert property (p_latch_low) else $error("latch low not held");

  property p_dir_input;
    @(posedge core_clk_i) disable iff (!nrst_i)
    !tx_pin_direction |=> !serial_tx_pin_oe_o;
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("pin driven in input mode");

endmodule // ubc_top

`default_nettype wire

// *** testbench/ubc_remote_node.sv ***
// Remote serial node: sends frames on the receive line, decodes the transmit line.
// Assumes the bench sets bit_clks, the bit length in core clocks.
`timescale 1ns/100ps
`default_nettype none
module ubc_remote_node (
  input  wire logic core_clk_i,
  input  wire logic line_i,
  output var  logic line_o
);
  int         bit_clks = 32;
  logic [7:0] d, rx_q[$];
  initial line_o = 1'b1;
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      line_o <= f[i];
      repeat (bit_clks) @(posedge core_clk_i);
    end
  endtask
  task automatic hold_line(input logic b);
    line_o <= b;
  endtask
  // Mid-bit sampling; a glitch only queues a junk byte
  always begin
    @(negedge line_i);
    for (int i = 0; i < 8; i++) begin
      repeat (i == 0 ? bit_clks * 3 / 2 : bit_clks) @(posedge core_clk_i);
      d[i] = line_i;
    end
    rx_q.push_back(d);
    repeat (bit_clks * 2) @(posedge core_clk_i);
  end
endmodule // ubc_remote_node
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the serial port control block and a remote node.
// Assumes the transmit pad is pulled high while nobody drives it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       core_clk_i = 1'b0, nrst_i = 1'b0, wr = 1'b0, rd = 1'b0, t1 = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, v, seed = 8'h62;
  wire  [7:0] rdata;
  wire        tx_o, tx_oe, irq, rx_line;
  wire        tx_pin = tx_oe ? tx_o : 1'b1;
  int         n_mismatch = 0, num_checks = 0;
  // Per pass: control, doubling, irq enable, bit length in clocks
  logic [31:0] cfg[5] = '{32'h90009040, 32'h90801020, 32'h50808020, 32'h1080900c,
                          32'hd0809020};
  ubc_top u_ubc_top (.core_clk_i, .nrst_i, .reg_addr_i(addr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .t1_ovf_i(t1), .serial_irq_o(irq),
    .serial_rx_pin_i(rx_line), .serial_tx_pin_o(tx_o), .serial_tx_pin_oe_o(tx_oe));
  ubc_remote_node u_ubc_remote_node (.core_clk_i, .line_i(tx_pin), .line_o(rx_line));
  initial forever #2 core_clk_i = ~core_clk_i;
  // Timer 1 overflows every second clock
  always @(posedge core_clk_i) t1 <= ~t1;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    @(posedge core_clk_i);
    {wr, rd, addr, wd} <= {w, r, a, d};
  endtask
  // Read data stands only in the cycle after the read edge
  task automatic rdr(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    @(negedge core_clk_i);
    v = rdata;
  endtask
  task automatic wait_flag(input int k);
    for (int i = 0; i < 3000; i++) begin
      rdr(ubc_pkg::ADDR_SERIAL_CTRL);
      if (v[k] === 1'b1) return;
    end
    n_mismatch++;
    test_done();
  endtask
  initial begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rdr(ubc_pkg::ADDR_PORT0_LATCH);
    chk({v[7:1], tx_oe}, 8'hfe);
    rdr(8'h55);
    chk(v, 8'h00);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_BAUD_SOURCE, 8'hff);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_DIR, 8'h08);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_RELOAD_HIGH, 8'h03);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_RELOAD_LOW, 8'hff);
    for (int c = 0; c < 5; c++) begin
      u_ubc_remote_node.bit_clks = int'(cfg[c][7:0]);
      // Last pass runs from timer 1 overflows
      if (c == 4) bus(1'b1, 1'b0, ubc_pkg::ADDR_BAUD_SOURCE, 8'h00);
      bus(1'b1, 1'b0, ubc_pkg::ADDR_SERIAL_CTRL, cfg[c][31:24]);
      bus(1'b1, 1'b0, ubc_pkg::ADDR_POWER_DOUBLE, cfg[c][23:16]);
      bus(1'b1, 1'b0, ubc_pkg::ADDR_IRQ_ENABLE0, cfg[c][15:8]);
      seed = lfsr(seed);
      bus(1'b1, 1'b0, ubc_pkg::ADDR_SERIAL_DATA, seed);
      wait_flag(1);
      chk({7'h00, irq}, {7'h00, cfg[c][15:8] == 8'h90});
      chk(u_ubc_remote_node.rx_q.pop_front(), seed);
      seed = lfsr(seed);
      u_ubc_remote_node.send({2'b11, seed, 1'b0});
      wait_flag(0);
      chk({6'h00, v[1:0]}, 8'h03);
      rdr(ubc_pkg::ADDR_SERIAL_DATA);
      chk(v, seed);
      bus(1'b1, 1'b0, ubc_pkg::ADDR_SERIAL_CTRL, cfg[c][31:24] | 8'h03);
      $display("pass %0d done", c);
    end
    // Receiver blocked by direction, then by open drain; latch low pins the pad low
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_DIR, 8'h0c);
    u_ubc_remote_node.send({2'b11, 8'h5a, 1'b0});
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_DIR, 8'h08);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_OD, 8'h04);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_LATCH, 8'hf7);
    u_ubc_remote_node.send({2'b11, 8'h5a, 1'b0});
    rdr(ubc_pkg::ADDR_SERIAL_CTRL);
    chk({v[0], 5'h00, tx_oe, tx_pin}, 8'h02);
    // Open-drain pad: low is driven, high is left to the pull-up
    u_ubc_remote_node.hold_line(1'b0);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_OD, 8'h0c);
    rdr(ubc_pkg::ADDR_PORT0_LATCH);
    chk({v[3:2], 4'h0, tx_oe, tx_pin}, 8'h02);
    u_ubc_remote_node.hold_line(1'b1);
    bus(1'b1, 1'b0, ubc_pkg::ADDR_PORT0_LATCH, 8'hff);
    rdr(ubc_pkg::ADDR_PORT0_LATCH);
    chk({v[3:2], 4'h0, tx_oe, tx_pin}, 8'hc1);
    $display("pin test done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
